// >>> logic/iop_top.sv
// pin function, power and reset logic behind a 16-bit serial link
// assumes: host is master, frames are exactly 16 sclk falling edges,
// sync_b stays high at least 4 mclk periods between frames
//
// Contract
// - output-config bit n set makes pin n a general-purpose output.
// - data bits for pins not configured as outputs are ignored.
// - push/pull outputs drive high or low from the data register.
// - open-drain outputs drive low for 0 and release for 1.
// - data write sets configured outputs to the written ones and zeros.
// - input-config bit n set makes pin n a general-purpose input.
// - input-config write with read bit returns pin states next frame.
// - unselected pins read back as zero in an input readback.
// - three-state bits put their pins in high impedance.
// - pull-down bits connect the pin pull-down resistor.
// - each DAC powers down alone, output floats, value kept.
// - reference off after reset, on only with its enable bit.
// - ADC powered down while no pin is an ADC input.
// - global power-down bit stops DACs, reference and ADC together.
// - software reset restores all registers and pins to defaults.
// - reset pin falling edge does the same full reset.
// - readback-enable write with select returns that register next frame.
// - low two bits of readback register select the DAC load mode.
// - link carries 16-bit words, data sampled on falling sclk edge.
// - modes 00 immediate, 01 hold, 10 transfer-all with the mode left as it was.
`timescale 1ns/1ps
`include "iop_defines.svh"

module iop_top #(
  parameter int RST_CYCLES = `IOP_RST_TIME_US * `IOP_MCLK_MHZ
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic sync_b,
  input wire logic sdi,
  output logic sdo,
  input wire logic rst_pin_b,
  input wire logic [7:0] pin_i,
  output iop_pkg::iop_pins_type pins,
  output iop_pkg::iop_pwr_type pwr
);
  import iop_pkg::*;

  iop_link_type l;
  iop_link_type next_l;
  iop_core_type c;
  iop_core_type next_c;
  iop_word_type w;
  logic frame_hit;
  logic pin_fall;
  logic wr_hit;
  logic reset_hit;

  ////////////////////////////////////////////////////////////////////
  // defaults after any reset: pins pulled down, dac_auto on for mode 00, everything else off
  function automatic iop_core_type core_default();
    iop_core_type d;
    d = '0;
    d.pull = `IOP_PULL_RST;
    d.pins.pull_en = `IOP_PULL_RST;
    d.dac_load_control = `IOP_DAC_LOAD_CONTROL_NOW;
    d.pwr.dac_auto = 1'b1; // mode 00 is immediate update
    return d;
  endfunction

  // register contents as seen by readback, chosen by address code
  function automatic logic [10:0] reg_value(input iop_core_type s,
                                            input logic [3:0] a);
    logic [10:0] v;
    v = '0;
    if (a == `IOP_A_ADC_CFG) begin
      v = {3'h0, s.adc_en};
    end else if (a == `IOP_A_DAC_CFG) begin
      v = {3'h0, s.dac_en};
    end else if (a == `IOP_A_PULL_CFG) begin
      v = {3'h0, s.pull};
    end else if (a == `IOP_A_RB_DAC_LOAD_CONTROL) begin
      v = {4'h0, s.rb_en, s.rb_sel, s.dac_load_control};
    end else if (a == `IOP_A_GPO_CFG) begin
      v = {3'h0, s.gpo_en};
    end else if (a == `IOP_A_GPO_DAT) begin
      v = {3'h0, s.gpo_dat};
    end else if (a == `IOP_A_GPI_CFG) begin
      v = {3'h0, s.gpi_en};
    end else if (a == `IOP_A_PWR) begin
      v = {s.global_power_down_bit, s.ref_en, 1'b0, s.dac_pd};
    end else if (a == `IOP_A_OD_CFG) begin
      v = {3'h0, s.od_en};
    end else if (a == `IOP_A_TS_CFG) begin
      v = {3'h0, s.ts_en};
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // link side: shift on falling sclk, hand a whole word over by toggle
  always_comb begin
    next_l = l;
    if (sync_b) begin
      next_l.cnt = 4'h0;
    end else begin
      next_l.cnt = l.cnt + 4'h1;
      next_l.shift = {l.shift[13:0], sdi};
      // tx is quasi-static during a frame, so reading it here is safe
      next_l.sdo = c.tx[4'he - l.cnt];
      if (l.cnt == `IOP_LAST_BIT) begin
        next_l.rx = {l.shift, sdi};
        next_l.tgl = ~l.tgl;
        next_l.cnt = 4'h0;
        // first bit of the next frame is always a zero
        next_l.sdo = 1'b0;
      end
    end
  end

  // sclk may stop between frames; nothing here waits for an idle edge
  always_ff @(negedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  assign sdo = l.sdo;

  link_word_a: assert property (@(negedge sclk) disable iff (!rst_b)
    (!sync_b && l.cnt == `IOP_LAST_BIT) |=> (l.tgl != $past(l.tgl)))
    else $error("word toggle missing after sixteenth bit");

  bit_count_a: assert property (@(negedge sclk) disable iff (!rst_b)
    (!sync_b && l.cnt != `IOP_LAST_BIT) |=> (l.cnt == $past(l.cnt) + 4'h1))
    else $error("bit counter skipped inside a frame");

  ////////////////////////////////////////////////////////////////////
  // core side: synchronise, decode, hold configuration
  always_comb begin
    next_c = c;
    next_c.rx_sync = {c.rx_sync[1:0], l.tgl};
    next_c.rp_sync = {c.rp_sync[1:0], rst_pin_b};
    next_c.pin_s1 = pin_i;
    next_c.pin_s2 = c.pin_s1;
    frame_hit = c.rx_sync[2] ^ c.rx_sync[1];
    pin_fall = c.rp_sync[2] & ~c.rp_sync[1];
    // rx stands still until the next frame ends, long after this
    w = iop_word_type'(l.rx);
    // words during the reset time are dropped
    wr_hit = frame_hit && (c.busy_cnt == 14'h0) && !w.is_dac;
    reset_hit = pin_fall || (wr_hit && w.addr == `IOP_A_SW_RST);
    if (c.busy_cnt != 14'h0) begin
      next_c.busy_cnt = c.busy_cnt - 14'h1;
    end
    // readback data lives for one frame only
    if (frame_hit) begin
      next_c.tx = '0;
    end
    if (reset_hit) begin
      next_c = core_default();
      next_c.rx_sync = {c.rx_sync[1:0], l.tgl};
      next_c.rp_sync = {c.rp_sync[1:0], rst_pin_b};
      next_c.pin_s1 = pin_i;
      next_c.pin_s2 = c.pin_s1;
      next_c.busy_cnt = 14'(RST_CYCLES - 1);
    end else if (wr_hit) begin
      if (w.addr == `IOP_A_ADC_CFG) begin
        next_c.adc_en = w.data[7:0];
      end else if (w.addr == `IOP_A_DAC_CFG) begin
        next_c.dac_en = w.data[7:0];
      end else if (w.addr == `IOP_A_PULL_CFG) begin
        next_c.pull = w.data[7:0];
      end else if (w.addr == `IOP_A_GPO_CFG) begin
        next_c.gpo_en = w.data[7:0];
      end else if (w.addr == `IOP_A_OD_CFG) begin
        next_c.od_en = w.data[7:0];
      end else if (w.addr == `IOP_A_TS_CFG) begin
        next_c.ts_en = w.data[7:0];
      end else if (w.addr == `IOP_A_GPO_DAT) begin
        next_c.gpo_dat = (w.data[7:0] & c.gpo_en) | (c.gpo_dat & ~c.gpo_en);
      end else if (w.addr == `IOP_A_GPI_CFG) begin
        next_c.gpi_en = w.data[7:0];
        if (w.data[`IOP_B_GPI_RD]) begin
          next_c.tx = {8'h00, c.pin_s2 & w.data[7:0]};
        end
      end else if (w.addr == `IOP_A_PWR) begin
        next_c.dac_pd = w.data[7:0];
        next_c.ref_en = w.data[`IOP_B_REF_EN];
        next_c.global_power_down_bit = w.data[`IOP_B_GLOBAL_POWER_DOWN_BIT];
      end else if (w.addr == `IOP_A_RB_DAC_LOAD_CONTROL) begin
        next_c.rb_en = w.data[`IOP_B_RB_EN];
        next_c.rb_sel = w.data[5:2];
        if (w.data[`IOP_B_RB_EN]) begin
          next_c.tx = {1'b0, w.data[5:2], reg_value(c, w.data[5:2])};
        end
        if (w.data[1:0] == `IOP_DAC_LOAD_CONTROL_XFER) begin
          next_c.pwr.dac_xfer = 1'b1;
          next_c.dac_load_control = c.dac_load_control;
        end else begin
          next_c.dac_load_control = w.data[1:0];
        end
      end
    end
    // registered outputs follow current state one cycle later
    // three-state wins
    next_c.pins.pin_oe = c.gpo_en & ~c.ts_en & ~(c.od_en & c.gpo_dat);
    next_c.pins.pin_o = c.gpo_en & ~c.ts_en & ~c.od_en & c.gpo_dat;
    next_c.pins.pull_en = c.pull;
    next_c.pwr.dac_off = c.dac_pd | {8{c.global_power_down_bit}};
    next_c.pwr.ref_on = c.ref_en & ~c.global_power_down_bit;
    next_c.pwr.adc_on = (|c.adc_en) & ~c.global_power_down_bit;
    next_c.pwr.dac_auto = (c.dac_load_control == `IOP_DAC_LOAD_CONTROL_NOW);
    next_c.pwr.busy = (c.busy_cnt != 14'h0);
    if (!(wr_hit && !reset_hit && w.addr == `IOP_A_RB_DAC_LOAD_CONTROL
          && w.data[1:0] == `IOP_DAC_LOAD_CONTROL_XFER)) begin
      next_c.pwr.dac_xfer = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      c <= core_default();
    end else begin
      c <= next_c;
    end
  end

  assign pins = c.pins;
  assign pwr = c.pwr;

  ////////////////////////////////////////////////////////////////////
  // checks on the core domain
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  no_stray_drive_a: assert property (
    (c.pins.pin_oe & ~$past(c.gpo_en)) == 8'h00)
    else $error("pin driven without output select");

  data_mask_a: assert property (
    !reset_hit |=> ((c.gpo_dat ^ $past(c.gpo_dat)) & ~$past(c.gpo_en)) == 8'h00)
    else $error("data changed on a pin that is not an output");

  push_pull_a: assert property (
    (((c.pins.pin_o ^ $past(c.gpo_dat)) | ~c.pins.pin_oe)
      & $past(c.gpo_en & ~c.od_en & ~c.ts_en)) == 8'h00)
    else $error("push/pull pin not following data");

  open_drain_a: assert property (
    (c.pins.pin_o & $past(c.od_en)) == 8'h00)
    else $error("open-drain pin driven high");

  data_write_a: assert property (
    (wr_hit && !reset_hit && w.addr == `IOP_A_GPO_DAT)
      |=> (c.gpo_dat & $past(c.gpo_en)) == ($past(w.data[7:0]) & $past(c.gpo_en)))
    else $error("output data write lost");

  in_readback_a: assert property (
    (wr_hit && !reset_hit && w.addr == `IOP_A_GPI_CFG && w.data[`IOP_B_GPI_RD])
      |=> (c.tx & ~{8'h00, $past(w.data[7:0])}) == 16'h0000)
    else $error("unselected pin read back nonzero");

  three_state_a: assert property (
    (c.pins.pin_oe & $past(c.ts_en)) == 8'h00)
    else $error("three-state pin is driven");

  ref_gate_a: assert property (
    $rose(c.pwr.ref_on) |-> $past(c.ref_en && !c.global_power_down_bit))
    else $error("reference on without enable");

  adc_auto_a: assert property (
    c.pwr.adc_on == $past((|c.adc_en) && !c.global_power_down_bit))
    else $error("adc power not tracking pin use");

  global_power_down_bit_a: assert property (
    $past(c.global_power_down_bit) |-> (c.pwr.dac_off == 8'hff && !c.pwr.ref_on && !c.pwr.adc_on))
    else $error("global power-down incomplete");

  reset_pins_a: assert property (
    reset_hit |-> ##2 (c.pins.pull_en == `IOP_PULL_RST && c.pins.pin_oe == 8'h00
      && c.pwr.busy))
    else $error("pins not at default after reset");

  dac_load_control_oneshot_a: assert property (
    $rose(c.pwr.dac_xfer) |=> !c.pwr.dac_xfer && c.dac_load_control != `IOP_DAC_LOAD_CONTROL_XFER)
    else $error("transfer-all mode did not revert");

  gpo_store_a: assert property (
    (wr_hit && !reset_hit && w.addr == `IOP_A_GPO_CFG)
      |=> c.gpo_en == $past(w.data[7:0]))
    else $error("output select not stored");

  gpi_store_a: assert property (
    (wr_hit && !reset_hit && w.addr == `IOP_A_GPI_CFG)
      |=> c.gpi_en == $past(w.data[7:0]))
    else $error("input select not stored");

  in_sample_a: assert property (
    (wr_hit && !reset_hit && w.addr == `IOP_A_GPI_CFG && w.data[`IOP_B_GPI_RD])
      |=> c.tx[7:0] == $past(c.pin_s2 & w.data[7:0]))
    else $error("input states not loaded for readback");

  pull_follow_a: assert property (
    c.pins.pull_en == $past(c.pull))
    else $error("pull-down drive not following register");

  dac_single_a: assert property (
    !$past(c.global_power_down_bit) |-> c.pwr.dac_off == $past(c.dac_pd))
    else $error("channel power-down not following register");

  ref_reset_a: assert property (
    reset_hit |-> ##2 (!c.pwr.ref_on && !c.pwr.adc_on && c.pwr.dac_off == 8'h00))
    else $error("power controls not at default after reset");

  reset_regs_a: assert property (
    reset_hit |=> (c.gpo_en == 8'h00 && c.pull == `IOP_PULL_RST && !c.ref_en && !c.global_power_down_bit
      && c.dac_load_control == `IOP_DAC_LOAD_CONTROL_NOW && c.dac_pd == 8'h00))
    else $error("register not at default after reset");

  pin_reset_a: assert property (
    $fell(c.rp_sync[1]) |-> ##2 (c.pwr.busy && c.pins.pull_en == `IOP_PULL_RST))
    else $error("reset pin edge did not reset");

  rb_reply_a: assert property (
    (wr_hit && !reset_hit && w.addr == `IOP_A_RB_DAC_LOAD_CONTROL && w.data[`IOP_B_RB_EN])
      |=> c.tx[15:11] == {1'b0, $past(w.data[5:2])})
    else $error("readback reply header wrong");

  reply_clear_a: assert property (
    (frame_hit && !wr_hit) |=> c.tx == 16'h0000)
    else $error("stale reply left after a frame");

  dac_load_control_store_a: assert property (
    (wr_hit && !reset_hit && w.addr == `IOP_A_RB_DAC_LOAD_CONTROL && w.data[1:0] != `IOP_DAC_LOAD_CONTROL_XFER)
      |=> c.dac_load_control == $past(w.data[1:0]))
    else $error("load mode not stored");

  xfer_pulse_a: assert property (
    (wr_hit && !reset_hit && w.addr == `IOP_A_RB_DAC_LOAD_CONTROL && w.data[1:0] == `IOP_DAC_LOAD_CONTROL_XFER)
      |=> (c.pwr.dac_xfer && c.dac_load_control == $past(c.dac_load_control)))
    else $error("transfer-all did not pulse or changed the mode");

  whole_byte_a: assert property (
    (wr_hit && !reset_hit && w.addr == `IOP_A_PULL_CFG)
      |=> c.pull == $past(w.data[7:0]))
    else $error("pull-down pattern not stored whole");

endmodule

// >>> pkg/iop_defines.svh
// constants for the pin control and power block
// assumes: included by bare name wherever a number is needed
`ifndef IOP_DEFINES_SVH
`define IOP_DEFINES_SVH
// register address codes, word bits [14:11]
`define IOP_A_ADC_CFG 4'h4
`define IOP_A_DAC_CFG 4'h5
`define IOP_A_PULL_CFG 4'h6
`define IOP_A_RB_DAC_LOAD_CONTROL 4'h7
`define IOP_A_GPO_CFG 4'h8
`define IOP_A_GPO_DAT 4'h9
`define IOP_A_GPI_CFG 4'ha
`define IOP_A_PWR 4'hb
`define IOP_A_OD_CFG 4'hc
`define IOP_A_TS_CFG 4'hd
`define IOP_A_SW_RST 4'hf
// field positions inside the 11-bit data field
`define IOP_B_GPI_RD 10
`define IOP_B_RB_EN 6
`define IOP_B_GLOBAL_POWER_DOWN_BIT 10
`define IOP_B_REF_EN 9
// reset values and load modes
`define IOP_PULL_RST 8'hff
`define IOP_DAC_LOAD_CONTROL_NOW 2'h0
`define IOP_DAC_LOAD_CONTROL_HOLD 2'h1
`define IOP_DAC_LOAD_CONTROL_XFER 2'h2
// timing
`define IOP_MCLK_MHZ 40
`define IOP_RST_TIME_US 250
`define IOP_LAST_BIT 4'hf
`endif

// >>> pkg/iop_pkg.sv
// types shared by the pin control and power block
// assumes: constants come from iop_defines.svh
package iop_pkg;
  // one serial command word
  typedef struct packed {
    logic is_dac;
    logic [3:0] addr;
    logic [10:0] data;
  } iop_word_type;
  // digital pin drive towards the pad ring
  typedef struct packed {
    logic [7:0] pin_o;
    logic [7:0] pin_oe;
    logic [7:0] pull_en;
  } iop_pins_type;
  // power and load controls towards the analog side
  typedef struct packed {
    logic [7:0] dac_off;
    logic ref_on;
    logic adc_on;
    logic dac_auto;
    logic dac_xfer;
    logic busy;
  } iop_pwr_type;
  // link-side state, clocked by the serial clock
  typedef struct packed {
    logic [3:0] cnt;
    logic [14:0] shift;
    logic [15:0] rx;
    logic tgl;
    logic sdo;
  } iop_link_type;
  // core state, clocked by mclk
  typedef struct packed {
    logic [7:0] gpo_en;
    logic [7:0] gpo_dat;
    logic [7:0] gpi_en;
    logic [7:0] od_en;
    logic [7:0] ts_en;
    logic [7:0] pull;
    logic [7:0] dac_en;
    logic [7:0] adc_en;
    logic [7:0] dac_pd;
    logic ref_en;
    logic global_power_down_bit;
    logic [1:0] dac_load_control;
    logic rb_en;
    logic [3:0] rb_sel;
    logic [15:0] tx;
    logic [2:0] rx_sync;
    logic [2:0] rp_sync;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [13:0] busy_cnt;
    iop_pins_type pins;
    iop_pwr_type pwr;
  } iop_core_type;
endpackage

// >>> test/iop_host.sv
// host model: serial master sending framed 16-bit words, msb first
// assumes: device takes sdi on falling sclk and moves sdo on falling sclk
`timescale 1ns/1ps

module iop_host (
  output logic sclk,
  output logic sync_b,
  output logic sdi,
  input wire logic sdo
);
  ////////////////////////////////////////////////////////////////////
  // idle: clock parked high, frame deselected
  initial begin
    sclk = 1'b1;
    sync_b = 1'b1;
    sdi = 1'b0;
  end
  // framed word transfer
  // sclk only runs inside a frame; sdi flips after the last falling edge, before sync_b is released
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    #3;
    sync_b = 1'b0;
    for (int k = 15; k >= 0; k--) begin
      sdi = w[k];
      #7.5;
      r[k] = sdo; // read just before the falling edge moves it
      sclk = 1'b0;
      #7.5;
      sclk = 1'b1;
    end
    sdi = ~w[0];
    #7.5;
    sync_b = 1'b1;
    // gap far above four mclk so the word is decoded before the next
    #250;
  endtask
endmodule

// >>> test/iop_top_bench.sv
// bench for the pin control and power block, one task per scenario
// assumes: iop_host drives the link, the bench drives pads and resets
`timescale 1ns/1ps
`include "iop_defines.svh"

module iop_top_bench;
  import iop_pkg::*;
  logic mclk, rst_b, rst_pin_b, sclk, sync_b, sdi, sdo;
  logic [7:0] pin_i;
  iop_pins_type pins;
  iop_pwr_type pwr;
  logic [15:0] rsp;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int xfers = 0;

  iop_top #(.RST_CYCLES(20)) dut (.mclk(mclk), .rst_b(rst_b), .sclk(sclk),
    .sync_b(sync_b), .sdi(sdi), .sdo(sdo), .rst_pin_b(rst_pin_b),
    .pin_i(pin_i), .pins(pins), .pwr(pwr));
  iop_host h (.sclk(sclk), .sync_b(sync_b), .sdi(sdi), .sdo(sdo));

  ////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // count transfer pulses; cut a hang short
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (pwr.dac_xfer === 1'b1) begin
      xfers <= xfers + 1;
    end
    if (cycles == 5000) begin
      num_errors++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d, comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [10:0] d);
    h.xfer({1'b0, a, d}, rsp);
    @(negedge mclk);
  endtask
  // quiet during reset
  // no write until busy drops, bounded wait
  task automatic wait_idle();
    for (int i = 0; i < 100 && pwr.busy !== 1'b0; i++) @(negedge mclk);
    chk(pwr.busy, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    chk(pins.pull_en, `IOP_PULL_RST);
    chk(pins.pin_oe, 8'h00);
    chk({pwr.ref_on, pwr.adc_on, pwr.busy}, 3'b000);
    chk(pwr.dac_off, 8'h00);
  endtask
  task automatic t_outputs();
    wr(`IOP_A_GPO_CFG, 11'h00f);
    wr(`IOP_A_GPO_DAT, 11'h0a5);
    chk({pins.pin_oe, pins.pin_o}, 16'h0f05);
    wr(`IOP_A_GPO_CFG, 11'h08f);
    chk({pins.pin_oe, pins.pin_o}, 16'h8f05);
    wr(`IOP_A_GPO_DAT, 11'h0f0);
    chk({pins.pin_oe, pins.pin_o}, 16'h8f80);
    wr(`IOP_A_GPO_DAT, 11'h085);
    chk({pins.pin_oe, pins.pin_o}, 16'h8f85);
    wr(`IOP_A_OD_CFG, 11'h003);
    chk({pins.pin_oe, pins.pin_o}, 16'h8e84);
    wr(`IOP_A_TS_CFG, 11'h080);
    chk({pins.pin_oe, pins.pin_o}, 16'h0e04);
    wr(`IOP_A_PULL_CFG, 11'h030);
    chk(pins.pull_en, 8'h30);
  endtask
  task automatic t_readback();
    pin_i = 8'h9c;
    wr(`IOP_A_GPI_CFG, 11'h430);
    h.xfer(16'h0000, rsp);
    chk(rsp, 16'h0010);
    wr(`IOP_A_RB_DAC_LOAD_CONTROL, 11'h058);
    h.xfer(16'h0000, rsp);
    chk(rsp, {1'b0, `IOP_A_PULL_CFG, 11'h030});
    wr(`IOP_A_DAC_CFG, 11'h0c3);
    // converter word reuses the address bits but must leave config alone
    h.xfer({1'b1, `IOP_A_PULL_CFG, 11'h0ff}, rsp);
    chk(pins.pull_en, 8'h30);
    wr(`IOP_A_RB_DAC_LOAD_CONTROL, 11'h054);
    h.xfer(16'h0000, rsp);
    chk(rsp, {1'b0, `IOP_A_DAC_CFG, 11'h0c3});
  endtask
  task automatic t_dac_load_control();
    int x0;
    chk(pwr.dac_auto, 1'b1);
    wr(`IOP_A_RB_DAC_LOAD_CONTROL, {9'h000, `IOP_DAC_LOAD_CONTROL_HOLD});
    chk(pwr.dac_auto, 1'b0);
    x0 = xfers;
    wr(`IOP_A_RB_DAC_LOAD_CONTROL, {9'h000, `IOP_DAC_LOAD_CONTROL_XFER});
    chk(16'(xfers - x0), 16'd1);
    chk(pwr.dac_auto, 1'b0);
  endtask
  task automatic t_power();
    wr(`IOP_A_PWR, 11'h201);
    chk({pwr.ref_on, pwr.dac_off}, 9'h101);
    wr(`IOP_A_ADC_CFG, 11'h004);
    wr(`IOP_A_PWR, 11'h600);
    chk({pwr.ref_on, pwr.adc_on, pwr.dac_off}, 10'h0ff);
    wr(`IOP_A_PWR, 11'h200);
    chk({pwr.adc_on, pwr.dac_off}, 9'h100);
    wr(`IOP_A_ADC_CFG, 11'h000);
    chk(pwr.adc_on, 1'b0);
  endtask
  task automatic t_resets();
    wr(`IOP_A_SW_RST, 11'h000);
    chk(pwr.busy, 1'b1);
    wait_idle();
    t_defaults();
    wr(`IOP_A_PULL_CFG, 11'h000);
    rst_pin_b = 1'b0;
    repeat (10) @(negedge mclk);
    chk(pwr.busy, 1'b1);
    rst_pin_b = 1'b1;
    wait_idle();
    chk(pins.pull_en, `IOP_PULL_RST);
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    rst_pin_b = 1'b1;
    pin_i = 8'h00;
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    @(negedge mclk);
    t_defaults();
    t_outputs();
    t_readback();
    t_dac_load_control();
    t_power();
    t_resets();
    end_sim();
  end
endmodule
